// [logic/imp_meas_core.sv]
`timescale 1ns/1ps
module imp_meas_core #(
    parameter int DW = 20,
    parameter int NW = 16,
    parameter int FILT_UNIT_CYC_P = imp_pkg::FILT_UNIT_CYC,
    parameter int AZ_TICK_CYC_P = imp_pkg::AZ_TICK_CYC,
    parameter int BAUD_BASE_CYC_P = imp_pkg::BAUD_BASE_CYC
) (
    // Clock and reset.
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    // Converter samples.
    input wire logic ADC_VALID_I,
    input wire logic signed [DW-1:0] ADC_DATA_I,
    // Hold pin.
    input wire logic HOLD_I,
    // Function settings.
    input wire logic [imp_pkg::DEC_W-1:0] DEC_POINT_I,
    input wire logic [imp_pkg::DIV_W-1:0] DIVISION_I,
    input wire logic [imp_pkg::FILT_W-1:0] FILTER_I,
    input wire logic [imp_pkg::HMODE_W-1:0] HOLD_MODE_I,
    input wire logic [imp_pkg::CMODE_W-1:0] CMP_MODE_I,
    input wire logic [imp_pkg::HYS_W-1:0] HYST_I,
    input wire logic DAC_MODE_I,
    input wire logic signed [DW-1:0] DAC_CAP_I,
    input wire logic [imp_pkg::DEV_W-1:0] DEV_NUM_I,
    input wire logic [imp_pkg::BAUD_W-1:0] BAUD_SEL_I,
    input wire logic [imp_pkg::AZR_W-1:0] AZ_RANGE_I,
    input wire logic [imp_pkg::AZT_W-1:0] AZ_TIME_I,
    // Setpoints; in decision mode A is the lower and B the upper limit.
    input wire logic signed [DW-1:0] SP_A_I,
    input wire logic signed [DW-1:0] SP_B_I,
    input wire logic signed [DW-1:0] SP_C_I,
    input wire logic signed [DW-1:0] SP_D_I,
    // Serial command.
    input wire logic CMD_STB_I,
    input wire logic [imp_pkg::DEV_W-1:0] CMD_ADDR_I,
    // Display.
    output logic signed [DW-1:0] DISP_VALUE_O,
    output logic DISP_VALID_O,
    output logic [imp_pkg::DEC_W-1:0] DP_POS_O,
    output logic HOLD_ACTIVE_O,
    // Relays.
    output logic RELAY_OUT_A_O,
    output logic RELAY_OUT_B_O,
    output logic RELAY_OUT_C_O,
    output logic RELAY_OUT_D_O,
    // Analog output code.
    output logic signed [imp_pkg::DAC_W-1:0] DAC_CODE_O,
    // Serial control.
    output logic STREAM_MODE_O,
    output logic TX_REQ_O,
    output logic BAUD_TICK_O,
    output logic PRINT_SEL_O,
    output logic CFG_ERR_O
);
    import imp_pkg::*;

    localparam int SW = DW + NW;
    localparam int UCW = $clog2(FILT_UNIT_CYC_P + 1);
    localparam int ACW = $clog2(AZ_TICK_CYC_P + 1);
    localparam int BCW = $clog2(BAUD_BASE_CYC_P + 1);

    typedef struct packed {
        logic hs1;
        logic hs2;
        logic hs3;
        logic hold_lvl;
        logic signed [DW-1:0] raw;
        logic signed [SW-1:0] acc;
        logic [NW-1:0] n;
        logic [UCW-1:0] unit_cnt;
        logic [3:0] units;
        logic signed [DW-1:0] live;
        logic upd;
        logic signed [DW-1:0] az_off;
        logic [ACW-1:0] az_cnt;
        logic [AZT_W-1:0] az_tenths;
        logic hold_act;
        logic signed [DW-1:0] hold_val;
        logic signed [DW-1:0] shown;
        logic [3:0] relay;
        logic signed [DAC_W-1:0] dac;
        logic tx;
        logic [BCW-1:0] baud_cnt;
        logic baud_tick;
        logic [DEC_W-1:0] dp;
        logic stream;
        logic print;
        logic cfg_err;
    } imp_state_s;

    imp_state_s q;
    imp_state_s d;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic helpers.

    function automatic logic [DW:0] absv(input logic signed [DW-1:0] v);
        logic signed [DW:0] sv;
        sv = (DW+1)'(v);
        return (sv < 0) ? (DW+1)'(-sv) : (DW+1)'(sv);
    endfunction

    // Rounds half away from zero; a step of zero passes the value through.
    function automatic logic signed [DW-1:0] quantize(input logic signed [DW-1:0] v,
                                                      input logic [DIV_W-1:0] step);
        logic [DW:0] mag;
        logic [DW:0] st;
        logic [DW:0] r;
        mag = absv(v);
        st = (DW+1)'(step);
        r = (st == '0) ? mag : (mag + (st >> 1)) / st * st;
        return v[DW-1] ? DW'(-r) : DW'(r);
    endfunction

    function automatic logic hi_lim(input logic signed [DW-1:0] v, input logic signed [DW-1:0] sp,
                                    input logic [HYS_W-1:0] hys, input logic on);
        logic signed [DW+1:0] vv;
        logic signed [DW+1:0] ss;
        logic signed [DW+1:0] hh;
        vv = (DW+2)'(v);
        ss = (DW+2)'(sp);
        hh = $signed((DW+2)'(hys));
        if (vv >= ss) begin
            return 1'b1;
        end
        if (vv < ss - hh) begin
            return 1'b0;
        end
        return on;
    endfunction

    function automatic logic lo_lim(input logic signed [DW-1:0] v, input logic signed [DW-1:0] sp,
                                    input logic [HYS_W-1:0] hys, input logic on);
        logic signed [DW+1:0] vv;
        logic signed [DW+1:0] ss;
        logic signed [DW+1:0] hh;
        vv = (DW+2)'(v);
        ss = (DW+2)'(sp);
        hh = $signed((DW+2)'(hys));
        if (vv <= ss) begin
            return 1'b1;
        end
        if (vv > ss + hh) begin
            return 1'b0;
        end
        return on;
    endfunction

    // Display equal to the capacity gives full scale; beyond it the code saturates.
    function automatic logic signed [DAC_W-1:0] scale(input logic signed [DW-1:0] v,
                                                      input logic signed [DW-1:0] cap);
        logic signed [DW+15:0] p;
        if (cap == '0) begin
            return '0;
        end
        p = (DW+16)'(v) * (DW+16)'(DAC_FS) / (DW+16)'(cap);
        if (p > (DW+16)'(DAC_FS)) begin
            return DAC_W'(DAC_FS);
        end
        if (p < -(DW+16)'(DAC_FS)) begin
            return DAC_W'(-DAC_FS);
        end
        return DAC_W'(p);
    endfunction

    function automatic logic [4:0] baud_mult(input logic [BAUD_W-1:0] sel);
        unique case (sel)
            3'h0: return 5'h01;
            3'h1: return 5'h02;
            3'h2: return 5'h04;
            3'h3: return 5'h08;
            3'h4: return 5'h10;
            default: return 5'h18;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    logic signed [DW-1:0] corr;
    logic signed [DW-1:0] avg;
    logic signed [SW-1:0] quot;
    logic avg_vld;
    logic [3:0] win;
    logic rise;
    logic [AZT_W-1:0] az_lim;
    logic [BAUD_W-1:0] bsel;
    logic [BCW-1:0] bdiv;
    logic signed [DW-1:0] sp [4];

    assign sp[0] = SP_A_I;
    assign sp[1] = SP_B_I;
    assign sp[2] = SP_C_I;
    assign sp[3] = SP_D_I;

    always_comb begin
        d = q;
        d.hs1 = HOLD_I;
        d.hs2 = q.hs1;
        d.hs3 = q.hs2;
        if (q.hs2 == q.hs3) begin
            d.hold_lvl = q.hs3;
        end
        rise = (q.hs2 == q.hs3) && q.hs3 && !q.hold_lvl;
        d.upd = 1'b0;
        d.tx = 1'b0;
        d.baud_tick = 1'b0;
        d.dp = DEC_POINT_I; // RULE_01
        if (ADC_VALID_I) begin
            d.raw = ADC_DATA_I;
        end
        corr = ADC_DATA_I - q.az_off;
        avg = corr;
        avg_vld = 1'b0;
        quot = '0;
        // Block average over whole 1/8 s units; samples beyond 2^NW-1 are dropped.
        win = 4'(FILTER_I >> 2); // RULE_03
        if (win == 4'h0) begin
            avg_vld = ADC_VALID_I;
            d.acc = '0;
            d.n = '0;
            d.unit_cnt = '0;
            d.units = 4'h0;
        end else begin
            if (ADC_VALID_I && q.n != '1) begin
                d.acc = q.acc + SW'(corr);
                d.n = q.n + 1'b1;
            end
            if (q.unit_cnt >= UCW'(FILT_UNIT_CYC_P - 1)) begin
                d.unit_cnt = '0;
                if (q.units + 4'h1 >= win) begin // RULE_03
                    d.units = 4'h0;
                    if (q.n != '0) begin
                        quot = q.acc / SW'($signed({1'b0, q.n}));
                        avg = $signed(quot[DW-1:0]);
                        avg_vld = 1'b1;
                    end
                    d.acc = ADC_VALID_I ? SW'(corr) : '0;
                    d.n = ADC_VALID_I ? NW'(1) : '0;
                end else begin
                    d.units = q.units + 4'h1;
                end
            end else begin
                d.unit_cnt = q.unit_cnt + 1'b1;
            end
        end
        if (avg_vld) begin
            d.live = quantize(avg, DIVISION_I); // RULE_02
            d.upd = 1'b1;
        end

        // Auto-zero: dwell counted in 0.1 s ticks, judged on every new average.
        az_lim = (AZ_TIME_I > AZ_TIME_MAX) ? AZ_TIME_MAX : AZ_TIME_I;
        if (AZ_RANGE_I == '0 || AZ_TIME_I == '0) begin // RULE_18 RULE_19 RULE_23
            d.az_cnt = '0;
            d.az_tenths = '0;
        end else begin
            if (q.az_cnt >= ACW'(AZ_TICK_CYC_P - 1)) begin
                d.az_cnt = '0;
                if (q.az_tenths != '1) begin
                    d.az_tenths = q.az_tenths + 1'b1;
                end
            end else begin
                d.az_cnt = q.az_cnt + 1'b1;
            end
            if (avg_vld) begin
                if (absv(avg) > (DW+1)'(AZ_RANGE_I)) begin // RULE_18 RULE_23
                    d.az_cnt = '0;
                    d.az_tenths = '0;
                end else if (q.az_tenths >= az_lim) begin // RULE_19
                    d.az_off = q.az_off + avg;
                    d.az_cnt = '0;
                    d.az_tenths = '0;
                end
            end
        end

        // Hold capture.
        if (!d.hold_lvl) begin
            d.hold_act = 1'b0; // RULE_24
            d.hold_val = '0;
        end else if (rise) begin
            d.hold_act = 1'b1;
            case (HOLD_MODE_I)
                HOLD_RAW_SAMPLE, HOLD_FAST_PEAK: d.hold_val = q.raw; // RULE_05
                default: d.hold_val = q.live; // RULE_04
            endcase
        end else if (q.hold_act) begin
            case (HOLD_MODE_I)
                HOLD_DISP_PEAK: begin
                    if (q.upd && q.live > q.hold_val) begin
                        d.hold_val = q.live; // RULE_06
                    end
                end
                HOLD_ABS_PEAK: begin
                    if (q.upd && absv(q.live) > absv(q.hold_val)) begin
                        d.hold_val = q.live; // RULE_07
                    end
                end
                HOLD_FAST_PEAK: begin
                    if (ADC_VALID_I && ADC_DATA_I > q.hold_val) begin
                        d.hold_val = ADC_DATA_I; // RULE_08
                    end
                end
                default: begin
                end
            endcase
        end
        d.shown = d.hold_act ? d.hold_val : d.live;

        // Relays judge the value on the display one cycle earlier.
        unique case (CMP_MODE_I)
            CMP_DECISION: begin // RULE_09 RULE_11
                d.relay[0] = q.shown <= SP_A_I;
                d.relay[1] = q.shown >= SP_B_I;
                d.relay[2] = (q.shown > SP_A_I) && (q.shown < SP_B_I); // RULE_20
                d.relay[3] = 1'b0;
            end
            CMP_HIGH: begin // RULE_10
                for (int i = 0; i < 4; i++) begin
                    d.relay[i] = hi_lim(q.shown, sp[i], HYST_I, q.relay[i]); // RULE_11 RULE_21
                end
            end
            CMP_LOW: begin // RULE_10
                for (int i = 0; i < 4; i++) begin
                    d.relay[i] = lo_lim(q.shown, sp[i], HYST_I, q.relay[i]); // RULE_11 RULE_22
                end
            end
            CMP_LOW_HIGH: begin // RULE_10
                d.relay[0] = lo_lim(q.shown, SP_A_I, HYST_I, q.relay[0]); // RULE_22
                d.relay[1] = lo_lim(q.shown, SP_B_I, HYST_I, q.relay[1]); // RULE_22
                d.relay[2] = hi_lim(q.shown, SP_C_I, HYST_I, q.relay[2]); // RULE_21
                d.relay[3] = hi_lim(q.shown, SP_D_I, HYST_I, q.relay[3]); // RULE_21
            end
        endcase

        d.dac = scale(DAC_MODE_I ? q.raw : q.shown, DAC_CAP_I); // RULE_12 RULE_13 RULE_14

        // Serial reporting.
        d.stream = DEV_NUM_I == '0;
        if (d.stream) begin
            d.tx = d.upd; // RULE_15
        end else begin
            d.tx = CMD_STB_I && (CMD_ADDR_I == DEV_NUM_I) && (DEV_NUM_I <= DEV_MAX); // RULE_16
        end
        // Command mode cannot run above 9600; the printer also runs at 9600.
        bsel = BAUD_SEL_I;
        d.print = BAUD_SEL_I >= BAUD_PRINT;
        d.cfg_err = !d.stream && BAUD_SEL_I > BAUD_9600 && !d.print; // RULE_17
        if (d.print || d.cfg_err) begin
            bsel = BAUD_9600; // RULE_17
        end
        bdiv = BCW'(BAUD_BASE_CYC_P / int'(baud_mult(bsel)));
        if (q.baud_cnt >= bdiv - 1'b1) begin
            d.baud_cnt = '0;
            d.baud_tick = 1'b1;
        end else begin
            d.baud_cnt = q.baud_cnt + 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign DISP_VALUE_O = q.shown;
    assign DISP_VALID_O = q.upd;
    assign DP_POS_O = q.dp;
    assign HOLD_ACTIVE_O = q.hold_act;
    assign RELAY_OUT_A_O = q.relay[0];
    assign RELAY_OUT_B_O = q.relay[1];
    assign RELAY_OUT_C_O = q.relay[2];
    assign RELAY_OUT_D_O = q.relay[3];
    assign DAC_CODE_O = q.dac;
    assign STREAM_MODE_O = q.stream;
    assign TX_REQ_O = q.tx;
    assign BAUD_TICK_O = q.baud_tick;
    assign PRINT_SEL_O = q.print;
    assign CFG_ERR_O = q.cfg_err;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);

    a_dp_follow: assert property ($past(NRST_I) |-> DP_POS_O == $past(DEC_POINT_I)) // RULE_01
        else $error("Decimal point does not follow its setting.");
    a_step_multiple: assert property ((DISP_VALID_O && !HOLD_ACTIVE_O && $stable(DIVISION_I) // RULE_02
        && DIVISION_I != '0) |-> (absv(DISP_VALUE_O) % DIVISION_I) == 0)
        else $error("Display value is not a multiple of the step.");
    a_hold_frozen: assert property ((HOLD_ACTIVE_O && $past(HOLD_ACTIVE_O) // RULE_04 RULE_05
        && $past(HOLD_MODE_I) <= HOLD_RAW_SAMPLE) |-> $stable(DISP_VALUE_O))
        else $error("Sample hold value moved.");
    a_peak_rises: assert property ((HOLD_ACTIVE_O && $past(HOLD_ACTIVE_O) // RULE_06
        && $past(HOLD_MODE_I) == HOLD_DISP_PEAK) |-> DISP_VALUE_O >= $past(DISP_VALUE_O))
        else $error("Peak hold value fell.");
    a_hold_latency: assert property (($rose(HOLD_I) ##1 HOLD_I [*3]) |=> HOLD_ACTIVE_O)
        else $error("Hold did not engage four cycles after the pin rose.");
    a_hold_release: assert property (!q.hold_lvl |-> (!HOLD_ACTIVE_O // RULE_24
        && DISP_VALUE_O == q.live))
        else $error("Released hold still shows a held value.");
    a_dec_ok: assert property (($past(NRST_I) && $past(CMP_MODE_I) == CMP_DECISION) // RULE_20
        |-> (RELAY_OUT_C_O == ($past(DISP_VALUE_O) > $past(SP_A_I)
        && $past(DISP_VALUE_O) < $past(SP_B_I))))
        else $error("Within-limits relay wrong.");
    a_dec_no_d: assert property (CMP_MODE_I == CMP_DECISION |=> !RELAY_OUT_D_O) // RULE_09
        else $error("Fourth relay active in decision mode.");
    a_high_on: assert property (($past(CMP_MODE_I) == CMP_HIGH // RULE_21
        && $past(DISP_VALUE_O) >= $past(SP_A_I)) |-> RELAY_OUT_A_O)
        else $error("High limit relay not on at setpoint.");
    a_low_off: assert property (($past(CMP_MODE_I) == CMP_LOW && $past(DISP_VALUE_O) // RULE_22
        > $past(SP_A_I) + $signed({1'b0, $past(HYST_I)})) |-> !RELAY_OUT_A_O)
        else $error("Low limit relay not off above hysteresis band.");
    a_dac_full: assert property (($past(DAC_MODE_I) == 1'b0 && $past(DAC_CAP_I) != '0 // RULE_14
        && $past(DISP_VALUE_O) == $past(DAC_CAP_I)) |-> DAC_CODE_O == DAC_W'(DAC_FS))
        else $error("Capacity display does not give full scale.");
    a_stream_tx: assert property ((DEV_NUM_I == '0 && $past(DEV_NUM_I) == '0) // RULE_15
        |=> TX_REQ_O == DISP_VALID_O)
        else $error("Stream mode report not paired with display update.");
    a_cmd_tx: assert property ((TX_REQ_O && !STREAM_MODE_O) // RULE_16
        |-> $past(CMD_STB_I && CMD_ADDR_I == DEV_NUM_I))
        else $error("Command mode report without addressed command.");
    a_az_idle: assert property ((AZ_RANGE_I == '0 || AZ_TIME_I == '0) // RULE_18 RULE_19 RULE_23
        |=> $stable(q.az_off))
        else $error("Auto-zero moved while disabled.");
endmodule // imp_meas_core

// [logic/imp_pkg.sv]
// Summary of operation
// RULE_01: Decimal code 0-3 sets fractional digits.
// RULE_02: Display shows only multiples of step; in hold modes 1 and 4 the code shows unrounded raw values.
// RULE_03: Filter code averages over time window.
// RULE_04: Hold mode 0 freezes shown display.
// RULE_05: Hold mode 1 latches raw converter reading.
// RULE_06: Hold mode 2 keeps largest display value.
// RULE_07: Hold mode 3 keeps largest magnitude value.
// RULE_08: Hold mode 4 keeps largest raw input.
// RULE_09: Decision mode drives low, high, ok relays.
// RULE_10: Modes 1-3 drive four setpoint relays.
// RULE_11: Hysteresis zero disables; limit modes only.
// RULE_12: Analog mode 0 follows shown display.
// RULE_13: Analog mode 1 follows raw converter input.
// RULE_14: Capacity setting maps to analog full scale.
// RULE_15: Device number zero streams data continuously.
// RULE_16: Numbers 1-32 answer addressed commands only.
// RULE_17: Baud select; command mode up to 9600.
// RULE_18: Auto-zero band in counts, zero disables.
// RULE_19: Auto-zero dwell time in tenths, zero disables.
// RULE_20: Ok relay needs strictly between both limits.
// RULE_21: High limit on at setpoint, off below hysteresis.
// RULE_22: Low limit on at setpoint, off above hysteresis.
// RULE_23: Tracking needs both settings; leaving band restarts.
// RULE_24: Hold release returns to live display.
package imp_pkg;
    // Setting field widths.
    localparam int DEC_W = 2;
    localparam int DIV_W = 6;
    localparam int FILT_W = 6;
    localparam int HMODE_W = 3;
    localparam int CMODE_W = 2;
    localparam int HYS_W = 7;
    localparam int DEV_W = 6;
    localparam int BAUD_W = 3;
    localparam int AZR_W = 7;
    localparam int AZT_W = 6;
    localparam int DAC_W = 16;
    // Power-on defaults and upper limits of the front-panel settings.
    localparam logic [DEC_W-1:0] DEC_DEFAULT = 2'h1;
    localparam logic [DIV_W-1:0] DIV_DEFAULT = 6'h01;
    localparam logic [FILT_W-1:0] FILT_DEFAULT = 6'h08;
    localparam logic [HMODE_W-1:0] HMODE_DEFAULT = 3'h2;
    localparam logic [DEV_W-1:0] DEV_MAX = 6'h20;
    localparam logic [AZT_W-1:0] AZ_TIME_MAX = 6'h32;
    // Hold modes.
    localparam logic [HMODE_W-1:0] HOLD_DISP_SAMPLE = 3'h0;
    localparam logic [HMODE_W-1:0] HOLD_RAW_SAMPLE = 3'h1;
    localparam logic [HMODE_W-1:0] HOLD_DISP_PEAK = 3'h2;
    localparam logic [HMODE_W-1:0] HOLD_ABS_PEAK = 3'h3;
    localparam logic [HMODE_W-1:0] HOLD_FAST_PEAK = 3'h4;
    // Comparison modes.
    localparam logic [CMODE_W-1:0] CMP_DECISION = 2'h0;
    localparam logic [CMODE_W-1:0] CMP_HIGH = 2'h1;
    localparam logic [CMODE_W-1:0] CMP_LOW = 2'h2;
    localparam logic [CMODE_W-1:0] CMP_LOW_HIGH = 2'h3;
    // Baud selections; 0..5 are 2400..57600, 6 selects the printer.
    localparam logic [BAUD_W-1:0] BAUD_9600 = 3'h2;
    localparam logic [BAUD_W-1:0] BAUD_PRINT = 3'h6;
    // Analog code for full scale (+10 V or 20 mA).
    localparam int DAC_FS = 10000;
    // Timing.
    localparam int CLK_HZ = 25000000;
    localparam int FILT_UNIT_MS = 125;
    localparam int FILT_UNIT_CYC = CLK_HZ / 1000 * FILT_UNIT_MS;
    localparam int AZ_TICK_MS = 100;
    localparam int AZ_TICK_CYC = CLK_HZ / 1000 * AZ_TICK_MS;
    localparam int BAUD_BASE_BPS = 2400;
    localparam int BAUD_BASE_CYC = CLK_HZ / BAUD_BASE_BPS;
endpackage

// [tb/imp_sensor_model.sv]
`timescale 1ns/1ps
module imp_sensor_model #(
    parameter int DW = 20
) (
    // Clock.
    input wire logic clk_i,
    // Converter samples.
    output logic valid_o,
    output logic signed [DW-1:0] data_o
);
    initial begin
        valid_o = 1'b0;
        data_o = '0;
    end
    // Outside a valid cycle the bus shows the inverse, so stale data cannot pass as fresh.
    task automatic send(input logic signed [DW-1:0] v, input int gap);
        @(posedge clk_i);
        valid_o <= 1'b1;
        data_o <= v;
        @(posedge clk_i);
        valid_o <= 1'b0;
        data_o <= ~v;
        repeat (gap) @(posedge clk_i);
    endtask
endmodule // imp_sensor_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import imp_pkg::*;
    localparam int DW = 20;
    logic CLK_SYS_I = 1'b0, NRST_I = 1'b0, ADC_VALID_I, HOLD_I, DAC_MODE_I, CMD_STB_I;
    logic signed [DW-1:0] ADC_DATA_I, DAC_CAP_I, SP_A_I, SP_B_I, SP_C_I, SP_D_I, DISP_VALUE_O;
    logic [DEC_W-1:0] DEC_POINT_I, DP_POS_O;
    logic [DIV_W-1:0] DIVISION_I;
    logic [FILT_W-1:0] FILTER_I;
    logic [HMODE_W-1:0] HOLD_MODE_I;
    logic [CMODE_W-1:0] CMP_MODE_I;
    logic [HYS_W-1:0] HYST_I;
    logic [DEV_W-1:0] DEV_NUM_I, CMD_ADDR_I;
    logic [BAUD_W-1:0] BAUD_SEL_I;
    logic [AZR_W-1:0] AZ_RANGE_I;
    logic [AZT_W-1:0] AZ_TIME_I;
    logic signed [DAC_W-1:0] DAC_CODE_O;
    logic DISP_VALID_O, HOLD_ACTIVE_O, RELAY_OUT_A_O, RELAY_OUT_B_O, RELAY_OUT_C_O;
    logic RELAY_OUT_D_O, STREAM_MODE_O, TX_REQ_O, BAUD_TICK_O, PRINT_SEL_O, CFG_ERR_O;
    logic signed [31:0] exp_q[$];
    int n_mismatch = 0, tests_run = 0, n_tx = 0, n_tk = 0, t0, seed = 32'h1EBDAAC8;
    int steps[6] = '{1, 2, 5, 10, 20, 50};
    int dv[5] = '{-100, -99, 99, 100, 10000};
    int de[5] = '{4, 1, 1, 2, 2};
    int hm[10] = '{1, 1, 1, 1, 2, 2, 2, 2, 3, 3};
    int hv[10] = '{100, 95, 89, 95, 100, 105, 111, 105, 100, 111};
    int he[10] = '{1, 1, 0, 0, 1, 1, 0, 0, 1, 0};
    int azx[7] = '{3, 3, 9, 5, 5, 5, 5};
    int aze[7] = '{3, 0, 6, 2, 2, 2, 2};
    int hs[3] = '{-40, 22, -10};
    int held_e[5] = '{15, 13, 20, -40, 22};
    int bd[4][5] = '{'{5, 3, 10, 1, 0}, '{5, 2, 10, 0, 0}, '{0, 5, 60, 0, 0}, '{0, 6, 10, 0, 1}};

    always #20 CLK_SYS_I = ~CLK_SYS_I;

    imp_sensor_model #(.DW(DW)) u_imp_sensor_model (
        .clk_i(CLK_SYS_I), .valid_o(ADC_VALID_I), .data_o(ADC_DATA_I));

    imp_meas_core #(.DW(DW), .FILT_UNIT_CYC_P(50), .AZ_TICK_CYC_P(20), .BAUD_BASE_CYC_P(96))
    u_imp_meas_core (.CLK_SYS_I, .NRST_I, .ADC_VALID_I, .ADC_DATA_I, .HOLD_I, .DEC_POINT_I,
        .DIVISION_I, .FILTER_I, .HOLD_MODE_I, .CMP_MODE_I, .HYST_I, .DAC_MODE_I, .DAC_CAP_I,
        .DEV_NUM_I, .BAUD_SEL_I, .AZ_RANGE_I, .AZ_TIME_I, .SP_A_I, .SP_B_I, .SP_C_I, .SP_D_I,
        .CMD_STB_I, .CMD_ADDR_I, .DISP_VALUE_O, .DISP_VALID_O, .DP_POS_O, .HOLD_ACTIVE_O,
        .RELAY_OUT_A_O, .RELAY_OUT_B_O, .RELAY_OUT_C_O, .RELAY_OUT_D_O, .DAC_CODE_O,
        .STREAM_MODE_O, .TX_REQ_O, .BAUD_TICK_O, .PRINT_SEL_O, .CFG_ERR_O);

    // Ties round away from zero, matching the display rounding.
    function automatic int quant(input int x, input int s);
        int r;
        r = x % s;
        quant = x - r;
        if (2 * (r < 0 ? -r : r) >= s)
            quant = quant + (x < 0 ? -s : s);
    endfunction

    task automatic chk(input logic signed [31:0] got, input logic signed [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge CLK_SYS_I);
    endtask

    task automatic put(input int x, input int s);
        exp_q.push_back(quant(x, s));
        u_imp_sensor_model.send(x, 4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge CLK_SYS_I) begin
        n_tx += (TX_REQ_O === 1'b1);
        n_tk += (BAUD_TICK_O === 1'b1);
        if (DISP_VALID_O === 1'b1 && HOLD_ACTIVE_O !== 1'b1) begin
            if (exp_q.size() == 0)
                chk(1, 0);
            else
                chk(DISP_VALUE_O, exp_q.pop_front());
            if (DEV_NUM_I == 0)
                chk(TX_REQ_O, 1);
        end
    end

    initial begin
        tk(20000);
        n_mismatch++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {HOLD_I, DAC_MODE_I, CMD_STB_I, CMD_ADDR_I, HYST_I, CMP_MODE_I} = '0;
        {FILTER_I, AZ_RANGE_I, AZ_TIME_I, DEV_NUM_I} = '0;
        {DEC_POINT_I, DIVISION_I, HOLD_MODE_I, BAUD_SEL_I} = {DEC_DEFAULT, DIV_DEFAULT, 6'h12};
        {SP_A_I, SP_B_I, SP_C_I, SP_D_I} = {-20'sd100, 20'sd100, 40'h0};
        DAC_CAP_I = 20'sd10000;
        tk(8);
        NRST_I <= 1'b1;
        tk(2);
        foreach (steps[i]) begin
            DIVISION_I <= 6'(steps[i]);
            DEC_POINT_I <= 2'(i);
            repeat (3) put($random(seed) % 3000, steps[i]);
            chk(DP_POS_O, i % 4);
        end
        DIVISION_I <= 6'h01;
        foreach (dv[i]) begin
            put(dv[i], 1);
            chk({RELAY_OUT_A_O, RELAY_OUT_B_O, RELAY_OUT_C_O}, de[i]);
            chk(DAC_CODE_O, dv[i]);
        end
        DAC_CAP_I <= -20'sd20000;
        put(1000, 1);
        chk(DAC_CODE_O, -500);
        {DAC_CAP_I, DAC_MODE_I, DIVISION_I} <= {20'sd10000, 1'b1, 6'h32};
        put(1234, 50);
        chk(DAC_CODE_O, 1234);
        {HYST_I, SP_A_I, DIVISION_I} <= {7'h0A, 20'sd100, 6'h01};
        foreach (hv[i]) begin
            CMP_MODE_I <= 2'(hm[i]);
            put(hv[i], 1);
            chk(RELAY_OUT_A_O, he[i]);
            chk(RELAY_OUT_D_O, hm[i] != 2);
        end
        DIVISION_I <= 6'h05;
        for (int m = 0; m < 5; m++) begin
            HOLD_MODE_I <= 3'(m);
            put(13, 5);
            HOLD_I <= 1'b1;
            tk(6);
            chk(HOLD_ACTIVE_O, 1);
            foreach (hs[k]) u_imp_sensor_model.send(hs[k], 2);
            chk(DISP_VALUE_O, held_e[m]);
            HOLD_I <= 1'b0;
            tk(6);
            chk(DISP_VALUE_O, -10);
        end
        FILTER_I <= 6'h04;
        exp_q.push_back(-20);
        u_imp_sensor_model.send(-10, 2);
        u_imp_sensor_model.send(-31, 2);
        tk(45);
        chk(DISP_VALUE_O, -20);
        {FILTER_I, AZ_RANGE_I, AZ_TIME_I, DIVISION_I} <= {6'h00, 7'h05, 6'h01, 6'h01};
        foreach (azx[k]) begin
            if (k == 5)
                AZ_TIME_I <= 6'h00;
            if (k == 0 || k == 2 || k == 5)
                tk(25);
            exp_q.push_back(aze[k]);
            u_imp_sensor_model.send(azx[k], 4);
        end
        chk(DISP_VALUE_O, 2);
        DEV_NUM_I <= 6'h05;
        for (int a = 6; a >= 5; a--) begin
            {CMD_STB_I, CMD_ADDR_I} <= {1'b1, 6'(a)};
            tk(1);
            CMD_STB_I <= 1'b0;
            t0 = n_tx;
            tk(4);
            chk(n_tx - t0, a == 5);
        end
        foreach (bd[i]) begin
            {DEV_NUM_I, BAUD_SEL_I} <= {6'(bd[i][0]), 3'(bd[i][1])};
            tk(30);
            t0 = n_tk;
            tk(240);
            chk(n_tk - t0, bd[i][2]);
            chk(CFG_ERR_O, bd[i][3]);
            chk(PRINT_SEL_O, bd[i][4]);
            chk(STREAM_MODE_O, bd[i][0] == 0);
        end
        chk(exp_q.size(), 0);
        final_report();
    end
endmodule // tb_top
